/* File: rtl/lvex_pkg.sv */
// constants for the low-vector exception logic
package lvex_pkg;
    localparam int         IP_W           = 32;
    localparam int         VEC_W          = 8;
    localparam int         DBG_N          = 7;
    localparam int         DATA_W         = 32;
    // vector numbers
    localparam logic [7:0] VEC_DIVIDE     = 8'h00;
    localparam logic [7:0] VEC_DEBUG      = 8'h01;
    localparam logic [7:0] VEC_NMI        = 8'h02;
    localparam logic [7:0] VEC_BREAK      = 8'h03;
    localparam logic [7:0] VEC_OVERFLOW   = 8'h04;
    // debug condition bit positions (also debug status layout)
    localparam int         DBG_FETCH_BIT  = 0;
    localparam int         DBG_WRITE_BIT  = 1;
    localparam int         DBG_RW_BIT     = 2;
    localparam int         DBG_IO_BIT     = 3;
    localparam int         DBG_GDET_BIT   = 4;
    localparam int         DBG_STEP_BIT   = 5;
    localparam int         DBG_TASK_BIT   = 6;
    localparam logic [6:0] DBG_FAULT_MASK = 7'h11;
    localparam logic [6:0] DBG_TRAP_MASK  = 7'h6E;
    // reset values
    localparam logic [6:0] DBG_STATUS_RST = 7'h00;
    localparam logic [7:0] VEC_RST        = 8'h00;
    localparam logic [2:0] NMI_SYNC_RST   = 3'h7;
endpackage : lvex_pkg

/* File: rtl/lvex_unit.sv */
// exception detection and reporting for vectors 0 through 4
`timescale 1ns/10ps
// Function
// [RULE_01] zero divisor or oversized quotient raises vector 0
// [RULE_02] vector 0 is a fault, no error code, points at failing op, no commit
// [RULE_03] debug vector 1: fetch and general-detect fault, the other conditions trap
// [RULE_04] vector 1 has no error code; trap points next, fault points current
// [RULE_05] trap debug conditions let the causing op commit first
// [RULE_06] debug causes are recorded in the debug status register
// [RULE_07] active-low nmi pin requests vector 2 as a trap without error code
// [RULE_08] nmi taken only at a boundary after the op completes, points next
// [RULE_09] one-byte breakpoint op raises vector 3 as a trap
// [RULE_10] generic soft interrupt op with operand 3 also raises vector 3
// [RULE_11] breakpoint pushes no error code, points next, alters nothing
// [RULE_12] overflow-check op raises vector 4 trap only when signed overflow set
// [RULE_13] vector 4 pushes no error code and points after the check op
// [RULE_14] add and subtract set signed overflow and carry flags
// [RULE_15] no error code for maskable pin or generic soft interrupts
// [RULE_16] vector, class, error-code flag and return pointer presented together
module lvex_unit
    import lvex_pkg::*;
#(
    parameter int AW = IP_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              retire_valid_i,
    input  wire logic [AW-1:0]     instruction_pointer_i,
    input  wire logic [AW-1:0]     next_instruction_pointer_i,
    input  wire logic              quotient_op_i,
    input  wire logic              quotient_signed_op_i,
    input  wire logic              divisor_zero_i,
    input  wire logic              quotient_too_wide_i,
    input  wire logic              one_byte_break_op_i,
    input  wire logic              generic_soft_int_op_i,
    input  wire logic [VEC_W-1:0]  soft_int_operand_i,
    input  wire logic              overflow_check_op_i,
    input  wire logic [DBG_N-1:0]  debug_cond_i,
    input  wire logic              debug_status_clr_i,
    input  wire logic              alu_valid_i,
    input  wire logic              alu_sub_i,
    input  wire logic [DATA_W-1:0] alu_a_i,
    input  wire logic [DATA_W-1:0] alu_b_i,
    input  wire logic              nmi_pin_n_i,
    input  wire logic              maskable_int_req_i,
    input  wire logic [VEC_W-1:0]  maskable_int_vector_i,
    output logic                   exc_valid_o,
    output logic [VEC_W-1:0]       exc_vector_o,
    output logic                   exc_trap_o,
    output logic                   exc_err_code_o,
    output logic [AW-1:0]          exc_ret_ip_o,
    output logic                   exc_commit_o,
    output logic [DBG_N-1:0]       debug_status_reg_o,
    output logic                   signed_overflow_flag_o,
    output logic                   carry_out_flag_o
);

    logic [2:0]        nmi_sync;
    logic              nmi_level;
    logic              nmi_pending;
    logic [2:0]        next_nmi_sync;
    logic              next_nmi_level;
    logic              next_nmi_pending;
    logic              next_exc_valid;
    logic [VEC_W-1:0]  next_exc_vector;
    logic              next_exc_trap;
    logic [AW-1:0]     next_exc_ret_ip;
    logic [DBG_N-1:0]  next_debug_status;
    logic              next_of;
    logic              next_cf;
    logic [DBG_N-1:0]  dbg_fault;
    logic [DBG_N-1:0]  dbg_trap;
    logic [DBG_N-1:0]  dbg_set;
    logic [DATA_W-1:0] alu_b_eff;
    logic [DATA_W:0]   alu_sum;
    logic              nmi_taken;
    logic              nmi_fall;

    always_comb begin
        next_nmi_sync     = {nmi_sync[1:0], nmi_pin_n_i};
        // level only moves once the second and third stages agree
        next_nmi_level    = (nmi_sync[1] == nmi_sync[2]) ? nmi_sync[2] : nmi_level;
        nmi_fall          = nmi_level & ~next_nmi_level;
        dbg_fault         = debug_cond_i & DBG_FAULT_MASK;
        dbg_trap          = debug_cond_i & DBG_TRAP_MASK;
        dbg_set           = '0;
        nmi_taken         = 1'b0;
        next_exc_valid    = 1'b0;
        next_exc_vector   = exc_vector_o;
        next_exc_trap     = exc_trap_o;
        next_exc_ret_ip   = exc_ret_ip_o;
        if (retire_valid_i) begin
            next_exc_valid  = 1'b1;
            next_exc_trap   = 1'b1;
            next_exc_ret_ip = next_instruction_pointer_i; // RULE_04 RULE_08 RULE_11 RULE_13
            if (|dbg_fault) begin
                // pre-execution conditions win: the op has not run yet
                next_exc_vector = VEC_DEBUG; // RULE_03
                next_exc_trap   = 1'b0;
                next_exc_ret_ip = instruction_pointer_i; // RULE_04
                dbg_set         = dbg_fault; // RULE_06
            end else if (quotient_op_i && (divisor_zero_i || quotient_too_wide_i)) begin
                next_exc_vector = VEC_DIVIDE; // RULE_01
                next_exc_trap   = 1'b0; // RULE_02
                next_exc_ret_ip = instruction_pointer_i; // RULE_02
            end else if (one_byte_break_op_i) begin
                next_exc_vector = VEC_BREAK; // RULE_09
            end else if (generic_soft_int_op_i) begin
                next_exc_vector = soft_int_operand_i; // RULE_10
            end else if (overflow_check_op_i && signed_overflow_flag_o) begin
                next_exc_vector = VEC_OVERFLOW; // RULE_12
            end else if (|dbg_trap) begin
                next_exc_vector = VEC_DEBUG; // RULE_03
                dbg_set         = dbg_trap; // RULE_06
            end else if (nmi_pending) begin
                next_exc_vector = VEC_NMI; // RULE_07 RULE_08
                nmi_taken       = 1'b1;
            end else if (maskable_int_req_i) begin
                next_exc_vector = maskable_int_vector_i;
            end else begin
                next_exc_valid  = 1'b0;
                next_exc_trap   = exc_trap_o;
                next_exc_ret_ip = exc_ret_ip_o;
            end
        end
        // a falling edge in the taking cycle stays pending
        next_nmi_pending  = (nmi_pending & ~nmi_taken) | nmi_fall; // RULE_07
        // set wins over a simultaneous clear
        next_debug_status = (debug_status_clr_i ? '0 : debug_status_reg_o) | dbg_set; // RULE_06
        alu_b_eff         = alu_sub_i ? ~alu_b_i : alu_b_i;
        alu_sum           = {1'b0, alu_a_i} + {1'b0, alu_b_eff} + {{DATA_W{1'b0}}, alu_sub_i};
        next_of           = signed_overflow_flag_o;
        next_cf           = carry_out_flag_o;
        if (alu_valid_i) begin
            next_of = (alu_a_i[DATA_W-1] == alu_b_eff[DATA_W-1])
                      && (alu_sum[DATA_W-1] != alu_a_i[DATA_W-1]); // RULE_14
            // subtraction reports borrow, the inverse of the adder carry
            next_cf = alu_sub_i ? ~alu_sum[DATA_W] : alu_sum[DATA_W]; // RULE_14
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nmi_sync               <= NMI_SYNC_RST;
            nmi_level              <= 1'b1;
            nmi_pending            <= 1'b0;
            exc_valid_o            <= 1'b0;
            exc_vector_o           <= VEC_RST;
            exc_trap_o             <= 1'b0;
            exc_err_code_o         <= 1'b0;
            exc_ret_ip_o           <= '0;
            exc_commit_o           <= 1'b0;
            debug_status_reg_o     <= DBG_STATUS_RST;
            signed_overflow_flag_o <= 1'b0;
            carry_out_flag_o       <= 1'b0;
        end else begin
            nmi_sync               <= next_nmi_sync;
            nmi_level              <= next_nmi_level;
            nmi_pending            <= next_nmi_pending;
            exc_valid_o            <= next_exc_valid; // RULE_16
            exc_vector_o           <= next_exc_vector;
            exc_trap_o             <= next_exc_trap;
            // none of these vectors, pin or soft interrupts carry a code
            exc_err_code_o         <= 1'b0; // RULE_15
            exc_ret_ip_o           <= next_exc_ret_ip;
            // faults leave state untouched; traps commit the op first
            exc_commit_o           <= next_exc_valid & next_exc_trap; // RULE_05
            debug_status_reg_o     <= next_debug_status;
            signed_overflow_flag_o <= next_of;
            carry_out_flag_o       <= next_cf;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    logic div_hit;
    assign div_hit = retire_valid_i && quotient_op_i && (divisor_zero_i || quotient_too_wide_i) && !(|dbg_fault);

    div_fault_a: assert property (div_hit |=> exc_valid_o && exc_vector_o == VEC_DIVIDE && !exc_trap_o  // RULE_01
        && exc_ret_ip_o == $past(instruction_pointer_i))
        else $error("divide error not reported as fault on current op");
    div_nocommit_a: assert property (exc_valid_o && !exc_trap_o |-> !exc_commit_o) // RULE_02
        else $error("fault committed state");
    dbg_class_a: assert property (retire_valid_i && |dbg_fault |=> exc_vector_o == VEC_DEBUG && !exc_trap_o // RULE_03
        && exc_ret_ip_o == $past(instruction_pointer_i))
        else $error("debug fault class or pointer wrong");
    dbg_trap_ip_a: assert property (exc_valid_o && exc_vector_o == VEC_DEBUG && exc_trap_o // RULE_04
        |-> exc_ret_ip_o == $past(next_instruction_pointer_i) && exc_commit_o)
        else $error("debug trap pointer or commit wrong");
    dbg_commit_a: assert property (exc_valid_o && exc_trap_o |-> exc_commit_o) // RULE_05
        else $error("trap delivered without commit");
    dbg_record_a: assert property (retire_valid_i && |dbg_fault |=> (debug_status_reg_o & $past(dbg_fault)) // RULE_06
        == $past(dbg_fault))
        else $error("debug cause not recorded");
    nmi_take_a: assert property (retire_valid_i && nmi_pending && !(|debug_cond_i) && !quotient_op_i // RULE_07
        && !one_byte_break_op_i && !generic_soft_int_op_i && !overflow_check_op_i
        |=> exc_valid_o && exc_vector_o == VEC_NMI && exc_trap_o)
        else $error("pending nmi not taken at boundary");
    nmi_boundary_a: assert property (exc_valid_o && exc_vector_o == VEC_NMI |-> $past(retire_valid_i) // RULE_08
        && exc_ret_ip_o == $past(next_instruction_pointer_i))
        else $error("nmi taken off boundary");
    brk_trap_a: assert property (retire_valid_i && one_byte_break_op_i && !(|dbg_fault) && !div_hit // RULE_09
        |=> exc_vector_o == VEC_BREAK && exc_trap_o && exc_ret_ip_o == $past(next_instruction_pointer_i))
        else $error("breakpoint trap wrong");
    soft3_a: assert property (retire_valid_i && generic_soft_int_op_i && soft_int_operand_i == VEC_BREAK // RULE_10
        && !(|dbg_fault) && !div_hit && !one_byte_break_op_i |=> exc_vector_o == VEC_BREAK)
        else $error("soft interrupt 3 not vector 3");
    ovf_quiet_a: assert property (retire_valid_i && overflow_check_op_i && !signed_overflow_flag_o // RULE_12
        && debug_cond_i == '0 && !quotient_op_i && !one_byte_break_op_i && !generic_soft_int_op_i
        && !nmi_pending && !maskable_int_req_i |=> !exc_valid_o)
        else $error("overflow trap without flag");
    ovf_trap_a: assert property (exc_valid_o && exc_vector_o == VEC_OVERFLOW && $past(overflow_check_op_i) // RULE_13
        && !$past(generic_soft_int_op_i) && !$past(maskable_int_req_i)
        |-> exc_trap_o && exc_ret_ip_o == $past(next_instruction_pointer_i) && $past(signed_overflow_flag_o))
        else $error("overflow trap pointer wrong");
    flag_add_a: assert property (alu_valid_i && !alu_sub_i && alu_a_i == 32'h7FFFFFFF && alu_b_i == 32'h00000001 // RULE_14
        |=> signed_overflow_flag_o && !carry_out_flag_o)
        else $error("signed overflow flag not set on add");
    no_errcode_a: assert property (exc_valid_o |-> !exc_err_code_o) // RULE_15 RULE_16
        else $error("error code flagged");

    div_seen_c: cover property (exc_valid_o && exc_vector_o == VEC_DIVIDE);
    nmi_seen_c: cover property (exc_valid_o && exc_vector_o == VEC_NMI);
    ovf_seen_c: cover property (exc_valid_o && exc_vector_o == VEC_OVERFLOW);
    dbg_trap_c: cover property (exc_valid_o && exc_vector_o == VEC_DEBUG && exc_trap_o);

endmodule : lvex_unit

/* File: dv/lvex_nmi_src.sv */
// far-side stand-in that drives the active-low nmi pin
`timescale 1ns/10ps
module lvex_nmi_src (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic fire_i,
    output logic      nmi_pin_n_o
);
    int cnt;
    // held low for five cycles, longer than the sync chain needs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) cnt <= 0;
        else if (fire_i) cnt <= 5;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // idle level is high, as with a pull-up
    assign nmi_pin_n_o = (cnt == 0);
endmodule : lvex_nmi_src

/* File: dv/low_vector_exception_logic_tb_top.sv */
// self-checking bench for the low-vector exception logic
`timescale 1ns/10ps
module low_vector_exception_logic_tb_top
    import lvex_pkg::*;
();
    logic clk_i = 0, rst_b_i = 0;
    logic rv, qop, qs, dz, qw, bop, sop, ocop, dclr, av, asub, mreq, fire, nmi_n;
    logic [31:0] ip, nip, a, b;
    logic [7:0]  sopnd, mvec;
    logic [6:0]  dc;
    logic ev, et, ee, ec, of_o, cf_o;
    logic [7:0]  evec;
    logic [31:0] instruction_pointer;
    logic [6:0]  dst;
    int n_mismatch = 0, total_checks = 0, seed = 53;
    int m_of = 0, m_cf = 0, m_dst = 0, m_nmi = 0;
    always #5 clk_i = ~clk_i;
    lvex_nmi_src u_src (.clk_i(clk_i), .rst_b_i(rst_b_i), .fire_i(fire), .nmi_pin_n_o(nmi_n));
    lvex_unit dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .retire_valid_i(rv), .instruction_pointer_i(ip),
        .next_instruction_pointer_i(nip), .quotient_op_i(qop), .quotient_signed_op_i(qs), .divisor_zero_i(dz),
        .quotient_too_wide_i(qw), .one_byte_break_op_i(bop), .generic_soft_int_op_i(sop),
        .soft_int_operand_i(sopnd), .overflow_check_op_i(ocop), .debug_cond_i(dc), .debug_status_clr_i(dclr),
        .alu_valid_i(av), .alu_sub_i(asub), .alu_a_i(a), .alu_b_i(b), .nmi_pin_n_i(nmi_n),
        .maskable_int_req_i(mreq), .maskable_int_vector_i(mvec), .exc_valid_o(ev), .exc_vector_o(evec),
        .exc_trap_o(et), .exc_err_code_o(ee), .exc_ret_ip_o(instruction_pointer), .exc_commit_o(ec),
        .debug_status_reg_o(dst), .signed_overflow_flag_o(of_o), .carry_out_flag_o(cf_o));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // one retiring op; rv is left high so retires may run back to back
    task automatic ret(input logic q, z, w, bk, so, oc, mq, input logic [7:0] op, input logic [6:0] d);
        int v;
        int f;
        logic [6:0] fb;
        logic [6:0] tb;
        v = -1; f = 0; fb = d & DBG_FAULT_MASK; tb = d & DBG_TRAP_MASK;
        if (dclr) m_dst = 0;
        if (fb != 0) begin v = 1; f = 1; m_dst |= fb; end
        else if (q && (z || w)) begin v = 0; f = 1; end
        else if (bk) v = 3;
        else if (so) v = op;
        else if (oc && m_of != 0) v = 4;
        else if (tb != 0) begin v = 1; m_dst |= tb; end
        else if (m_nmi != 0) begin v = 2; m_nmi = 0; end
        else if (mq) v = op;
        ip = $random(seed); nip = ip + 32'h0000_0003; qs = $random(seed);
        {rv, qop, dz, qw, bop, sop, ocop, mreq} = {1'b1, q, z, w, bk, so, oc, mq};
        sopnd = op; mvec = op; dc = d;
        @(posedge clk_i);
        #1;
        chk(ev, v >= 0, "valid");
        if (v >= 0) begin
            chk(evec, v, "vector");
            chk(et, !f, "class");
            chk(ee, 0, "errcode");
            chk(instruction_pointer, f ? ip : nip, "ret ip");
            chk(ec, !f, "commit");
        end
        chk(dst, m_dst, "dbg status");
    endtask : ret
    task automatic alu(input logic s, input logic [31:0] x, input logic [31:0] y);
        logic [32:0] r;
        r = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
        m_cf = r[32];
        m_of = (s ? x[31] != y[31] : x[31] == y[31]) && (r[31] != x[31]);
        {rv, av, asub, a, b} = {1'b0, 1'b1, s, x, y};
        @(posedge clk_i);
        #1;
        chk(of_o, m_of, "of");
        chk(cf_o, m_cf, "cf");
    endtask : alu
    task automatic idle(input int n, input string what);
        {rv, av, dclr, fire} = '0;
        repeat (n) @(posedge clk_i);
        #1;
        $display("test %s done", what);
    endtask : idle
    initial begin
        {rv, qop, qs, dz, qw, bop, sop, ocop, dclr, av, asub, mreq, fire} = '0;
        {ip, nip, a, b, sopnd, mvec, dc} = '0;
        repeat (6) @(posedge clk_i);
        #1 rst_b_i = 1;
        ret(1, 1, 0, 0, 0, 0, 0, 0, 0);
        ret(1, 0, 1, 0, 0, 0, 0, 0, 0);
        ret(1, 0, 0, 0, 0, 0, 0, 0, 0);
        idle(1, "divide");
        for (int i = 0; i < DBG_N; i++) ret(0, 0, 0, 0, 0, 0, 0, 0, 7'h01 << i);
        ret(0, 0, 0, 0, 0, 0, 0, 0, 7'h7F);
        // clear and a new cause in one cycle: the cause survives
        dclr = 1;
        ret(0, 0, 0, 0, 0, 0, 0, 0, 7'h20);
        dclr = 0;
        idle(1, "debug");
        dclr = 1;
        m_dst = 0;
        @(posedge clk_i);
        #1;
        dclr = 0;
        chk(dst, 0, "dbg clear");
        ret(0, 0, 0, 1, 0, 0, 0, 0, 0);
        ret(0, 0, 0, 0, 1, 0, 0, 8'h03, 0);
        ret(0, 0, 0, 0, 1, 0, 0, $random(seed), 0);
        ret(0, 0, 0, 0, 0, 0, 1, $random(seed), 0);
        ret(1, 1, 0, 1, 0, 0, 0, 0, 0);
        idle(1, "break");
        alu(0, 32'h7FFF_FFFF, 32'h0000_0001);
        ret(0, 0, 0, 0, 0, 1, 0, 0, 0);
        alu(1, 32'h0000_0000, 32'h0000_0001);
        ret(0, 0, 0, 0, 0, 1, 0, 0, 0);
        for (int i = 0; i < 40; i++) alu($random(seed), $random(seed), $random(seed));
        idle(1, "overflow");
        fire = 1;
        @(posedge clk_i);
        #1;
        fire = 0;
        idle(10, "nmi wait");
        m_nmi = 1;
        ret(0, 0, 0, 1, 0, 0, 0, 0, 0);
        ret(0, 0, 0, 0, 0, 0, 1, 8'h21, 0);
        idle(1, "nmi");
        for (int i = 0; i < 60; i++) ret($random(seed), $random(seed), $random(seed), $random(seed),
            $random(seed), $random(seed), $random(seed), $random(seed), $random(seed) & $random(seed));
        idle(2, "random");
        results();
    end
    initial begin
        #200000;
        n_mismatch++;
        $display("BAD %0t run did not finish", $time);
        results();
    end
endmodule : low_vector_exception_logic_tb_top
